// ==== common/cid_pkg.sv ====
package cid_pkg;

	// Word and field widths
	localparam int INSTR_W   = 14;
	localparam int DATA_W    = 8;
	localparam int FADDR_W   = 7;
	localparam int JUMP_W    = 11;
	localparam int BSEL_W    = 3;
	localparam int NIB_W     = 4;

	// Field positions in the instruction word
	localparam int PFX_HI    = 13;
	localparam int PFX_LO    = 12;
	localparam int NIB_HI    = 11;
	localparam int NIB_LO    = 8;
	localparam int DEST_BIT  = 7;
	localparam int BOP_HI    = 11;
	localparam int BOP_LO    = 10;
	localparam int BSEL_HI   = 9;
	localparam int BSEL_LO   = 7;
	localparam int LIT_HI    = 7;
	localparam int F_HI      = 6;
	localparam int JUMP_BIT  = 11;

	// Instruction classes
	localparam logic [1:0] PFX_BYTE = 2'h0;
	localparam logic [1:0] PFX_BIT  = 2'h1;
	localparam logic [1:0] PFX_CTRL = 2'h2;
	localparam logic [1:0] PFX_LIT  = 2'h3;

	// Byte-oriented opcode nibbles
	localparam logic [3:0] OP_MOVWF = 4'h0;
	localparam logic [3:0] OP_CLR   = 4'h1;
	localparam logic [3:0] OP_SUB   = 4'h2;
	localparam logic [3:0] OP_DEC   = 4'h3;
	localparam logic [3:0] OP_IOR   = 4'h4;
	localparam logic [3:0] OP_AND   = 4'h5;
	localparam logic [3:0] OP_XOR   = 4'h6;
	localparam logic [3:0] OP_ADD   = 4'h7;
	localparam logic [3:0] OP_MOV   = 4'h8;
	localparam logic [3:0] OP_COM   = 4'h9;
	localparam logic [3:0] OP_INC   = 4'hA;
	localparam logic [3:0] OP_DECSZ = 4'hB;
	localparam logic [3:0] OP_RRC   = 4'hC;
	localparam logic [3:0] OP_RLC   = 4'hD;
	localparam logic [3:0] OP_SWAP  = 4'hE;
	localparam logic [3:0] OP_INCSZ = 4'hF;

	// Bit-oriented operations
	localparam logic [1:0] BOP_CLR  = 2'h0;
	localparam logic [1:0] BOP_SET  = 2'h1;
	localparam logic [1:0] BOP_TSC  = 2'h2;
	localparam logic [1:0] BOP_TSS  = 2'h3;

	// Literal operation nibbles, for casez
	localparam logic [3:0] LOP_MOV  = 4'b00??;
	localparam logic [3:0] LOP_RET  = 4'b01??;
	localparam logic [3:0] LOP_IOR  = 4'h8;
	localparam logic [3:0] LOP_AND  = 4'h9;
	localparam logic [3:0] LOP_XOR  = 4'hA;
	localparam logic [3:0] LOP_SUB  = 4'b110?;
	localparam logic [3:0] LOP_ADD  = 4'b111?;

	// Fixed control words
	localparam logic [13:0] W_NOP    = 14'h0000;
	localparam logic [13:0] W_RETURN = 14'h0008;
	localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0009;
	localparam logic [13:0] W_SLEEP  = 14'h0063;
	localparam logic [13:0] W_WATCHDOG_CLEAR_OP = 14'h0064;

	// Defaults and reset values
	localparam int         PC_W_DEF       = 11;
	localparam int         STACK_DEPTH_DEF = 8;
	localparam logic [6:0] PORT_ADDR_DEF  = 7'h06;
	localparam logic [6:0] TIMER_ADDR_DEF = 7'h01;
	localparam logic       TO_RST         = 1'h1;
	localparam logic       PD_RST         = 1'h1;
	localparam logic [7:0] DATA_ZERO      = 8'h00;
	localparam int         CLK_PER_CYCLE  = 4;

	typedef enum logic [1:0] {
		PH_Q0 = 2'b00,
		PH_Q1 = 2'b01,
		PH_Q2 = 2'b10,
		PH_Q3 = 2'b11
	} cid_phase_type;

	typedef enum logic [3:0] {
		ALU_PASS_A = 4'h0,
		ALU_PASS_B = 4'h1,
		ALU_CLR    = 4'h2,
		ALU_ADD    = 4'h3,
		ALU_SUB    = 4'h4,
		ALU_AND    = 4'h5,
		ALU_OR     = 4'h6,
		ALU_XOR    = 4'h7,
		ALU_COM    = 4'h8,
		ALU_DEC    = 4'h9,
		ALU_INC    = 4'hA,
		ALU_RLC    = 4'hB,
		ALU_RRC    = 4'hC,
		ALU_SWAP   = 4'hD,
		ALU_BCLR   = 4'hE,
		ALU_BSET   = 4'hF
	} cid_alu_op_type;

endpackage

// ==== sim/cid_core_asserts.sv ====
`timescale 1ns/1ps
module cid_core_asserts
	import cid_pkg::*;
#(
	parameter int         PC_W       = PC_W_DEF,
	parameter logic [6:0] TIMER_ADDR = TIMER_ADDR_DEF
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_b_i,
	// Watched ports
	input  wire logic [PC_W-1:0]    pm_addr_o,
	input  wire logic [FADDR_W-1:0] rf_addr_o,
	input  wire logic               rf_rd_en_o,
	input  wire logic               rf_wr_en_o,
	input  wire logic               tmr_pre_assigned_i,
	input  wire logic               tmr_pre_clr_o,
	input  wire logic               wake_i,
	input  wire logic               sleep_o,
	input  wire logic               wdt_clr_o,
	input  wire logic               gie_set_o,
	input  wire logic               timeout_flag_o,
	input  wire logic               powerdown_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_rmw; rf_wr_en_o |-> $past(rf_rd_en_o, 2) && rf_addr_o == $past(rf_addr_o, 2); endproperty
	a_rmw: assert property (p_rmw) else $error("write without read");
	property p_rd_gap; rf_rd_en_o |=> !rf_rd_en_o [*3]; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
	property p_wr_gap; rf_wr_en_o |=> !rf_wr_en_o [*3]; endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("writes too close");
	property p_pc_gap; $changed(pm_addr_o) |=> $stable(pm_addr_o) [*3]; endproperty
	a_pc_gap: assert property (p_pc_gap) else $error("pc moved mid cycle");
	property p_pre_clr; tmr_pre_clr_o |-> rf_wr_en_o && rf_addr_o == TIMER_ADDR && tmr_pre_assigned_i; endproperty
	a_pre_clr: assert property (p_pre_clr) else $error("stray prescaler clear");
	property p_pre_need; rf_wr_en_o && rf_addr_o == TIMER_ADDR && tmr_pre_assigned_i |-> tmr_pre_clr_o; endproperty
	a_pre_need: assert property (p_pre_need) else $error("missing prescaler clear");
	property p_wdt; wdt_clr_o |=> timeout_flag_o && powerdown_flag_o; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear flags wrong");
	property p_sleep_flags; sleep_o |-> timeout_flag_o && !powerdown_flag_o; endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("standby flags wrong");
	property p_sleep_idle; sleep_o && !wake_i |=> $stable(pm_addr_o) && !rf_rd_en_o; endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("activity in standby");
	property p_gie; gie_set_o |-> !rf_wr_en_o ##1 !gie_set_o [*3]; endproperty
	a_gie: assert property (p_gie) else $error("interrupt return pulse wrong");

	c_pre: cover property (tmr_pre_clr_o);
	c_wdt: cover property (wdt_clr_o);
	c_sleep: cover property ($rose(sleep_o));
endmodule

bind cid_core cid_core_asserts #(.PC_W(PC_W), .TIMER_ADDR(TIMER_ADDR)) u_cid_core_asserts (
	.clk_i, .rst_b_i, .pm_addr_o, .rf_addr_o, .rf_rd_en_o, .rf_wr_en_o, .tmr_pre_assigned_i,
	.tmr_pre_clr_o, .wake_i, .sleep_o, .wdt_clr_o, .gie_set_o, .timeout_flag_o, .powerdown_flag_o);

// ==== sim/cid_core_tb.sv ====
`timescale 1ns/1ps
module cid_core_tb;
	import cid_pkg::*;
	typedef struct packed {
		logic [6:0]  addr;
		logic [7:0]  data;
		logic [31:0] edge_n;
	} cid_note_type;
	logic        clk_i, rst_b_i, ce_i, wake_i, tmr_pre_assigned_i;
	logic [10:0] pm_addr_o;
	logic [13:0] pm_data_i;
	logic [6:0]  rf_addr_o;
	logic [7:0]  rf_rd_data_i, rf_wr_data_o, port_pins_i, w_o;
	logic        rf_rd_en_o, rf_wr_en_o, tmr_pre_clr_o, sleep_o, wdt_clr_o, gie_set_o;
	logic        carry_o, digit_carry_flag_o, zero_o, timeout_flag_o, powerdown_flag_o;
	logic [7:0]  mw;
	logic        mc, mdc, mz, mto, mpd;
	logic [7:0]  rfm [0:127];
	logic [13:0] prog [0:63];
	logic [13:0] dir [0:26] = '{14'h300F, 14'h3E01, 14'h00A0, 14'h2008, 14'h00A1, 14'h0064,
		14'h280C, 14'h0000, 14'h3480, 14'h0009, 14'h0000, 14'h0000, 14'h0BA2, 14'h00A3,
		14'h1C06, 14'h00A4, 14'h1886, 14'h00A5, 14'h0886, 14'h0181, 14'h3C05, 14'h0DA0,
		14'h0C20, 14'h0FA5, 14'h00A6, 14'h2009, 14'h0063};
	cid_note_type q [$];
	int          fail_count, tests_run, ec, t, i;

	cid_core u_cid_core (.clk_i, .rst_b_i, .ce_i, .pm_addr_o, .pm_data_i, .rf_addr_o, .rf_rd_en_o,
		.rf_rd_data_i, .rf_wr_en_o, .rf_wr_data_o, .port_pins_i, .tmr_pre_assigned_i,
		.tmr_pre_clr_o, .wake_i, .sleep_o, .wdt_clr_o, .gie_set_o, .w_o, .carry_o,
		.digit_carry_flag_o, .zero_o, .timeout_flag_o, .powerdown_flag_o);
	cid_mem_model u_cid_mem_model (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
		.rf_addr_i(rf_addr_o), .rf_rd_en_i(rf_rd_en_o), .rf_rd_data_o(rf_rd_data_i),
		.rf_wr_en_i(rf_wr_en_o), .rf_wr_data_i(rf_wr_data_o));

	function automatic logic [9:0] addc(input logic [7:0] a, b, input logic ci);
		logic [4:0] h;
		logic [8:0] s;
		h = a[3:0] + b[3:0] + ci;
		s = a + b + ci;
		return {s[8], h[4], s[7:0]};
	endfunction

	// Reference run of prog; queues every expected file write with its clock edge
	task automatic iss();
		logic [13:0] iw;
		logic [7:0]  f, r, k;
		logic [10:0] pc;
		logic [10:0] stk [0:7];
		logic [2:0]  sp;
		logic        wr, sk;
		int          kc;
		pc = 0;
		sp = 0;
		kc = 0;
		forever begin
			iw = prog[pc];
			pc++;
			k = iw[7:0];
			f = (iw[6:0] == PORT_ADDR_DEF) ? port_pins_i : rfm[iw[6:0]];
			r = f;
			wr = 1'b0;
			sk = 1'b0;
			if (iw == W_SLEEP) begin
				{mto, mpd} = 2'h2;
				return;
			end
			case (iw[13:12])
			PFX_BYTE: begin
				wr = iw[7];
				case (iw[11:8])
				OP_MOVWF: begin
					r = mw;
					if (iw == W_WATCHDOG_CLEAR_OP)
						{mto, mpd} = 2'h3;
					if (iw == W_RETURN || iw == W_INTERRUPT_RETURN) begin
						sp--;
						pc = stk[sp];
						kc++;
					end
				end
				OP_CLR: r = 8'h00;
				OP_SUB: {mc, mdc, r} = addc(f, ~mw, 1'b1);
				OP_DEC: r = f - 8'h01;
				OP_IOR: r = f | mw;
				OP_AND: r = f & mw;
				OP_XOR: r = f ^ mw;
				OP_ADD: {mc, mdc, r} = addc(mw, f, 1'b0);
				OP_COM: r = ~f;
				OP_INC: r = f + 8'h01;
				OP_DECSZ: begin
					r = f - 8'h01;
					sk = (r == 8'h00);
				end
				OP_RRC: {r, mc} = {mc, f};
				OP_RLC: {mc, r} = {f, mc};
				OP_SWAP: r = {f[3:0], f[7:4]};
				OP_INCSZ: begin
					r = f + 8'h01;
					sk = (r == 8'h00);
				end
				default: r = f;
				endcase
				if (iw[11:8] inside {[4'h1:4'hA]})
					mz = (r == 8'h00);
				if (!wr)
					mw = r;
			end
			PFX_BIT: begin
				r[iw[9:7]] = iw[10];
				wr = !iw[11];
				sk = iw[11] && (f[iw[9:7]] == iw[10]);
			end
			PFX_CTRL: begin
				if (!iw[11]) begin
					stk[sp] = pc;
					sp++;
				end
				pc = iw[10:0];
				kc++;
			end
			default: begin
				casez (iw[11:8])
				LOP_MOV: mw = k;
				LOP_RET: begin
					mw = k;
					sp--;
					pc = stk[sp];
					kc++;
				end
				LOP_IOR: mw = mw | k;
				LOP_AND: mw = mw & k;
				LOP_XOR: mw = mw ^ k;
				LOP_SUB: {mc, mdc, mw} = addc(k, ~mw, 1'b1);
				default: {mc, mdc, mw} = addc(mw, k, 1'b0);
				endcase
				if (iw[11])
					mz = (mw == 8'h00);
			end
			endcase
			if (wr) begin
				q.push_back({iw[6:0], r, 32'(6 + 4 * kc)});
				rfm[iw[6:0]] = r;
			end
			if (sk)
				pc++;
			kc = kc + 1 + int'(sk);
		end
	endtask

	function automatic logic [13:0] rnd_word();
		logic [13:0] iw;
		int          k;
		iw = 14'($urandom);
		k = $urandom % 8;
		if (iw[13:12] == 2'h2)
			iw[13:12] = 2'h3;
		if (!iw[13])
			iw[6:0] = (k == 0) ? 7'h01 : (k == 1) ? 7'h06 : 7'(8'h1E + k);
		if (iw[13:8] == 6'h00)
			iw[7] = 1'b1;
		if (iw[13:10] == 4'hD)
			iw[11:10] = 2'h0;
		if (iw[13:8] == 6'h3B)
			iw[8] = 1'b0;
		return iw;
	endfunction

	task automatic chk_st(input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_wr(input cid_note_type got);
		cid_note_type exp;
		exp = (q.size() > 0) ? q.pop_front() : '1;
		chk_st(64'(got), 64'(exp));
	endtask

	task automatic run_prog();
		int n;
		for (n = 0; n < 64; n++)
			u_cid_mem_model.rom[n] = prog[n];
		for (n = 0; n < 128; n++)
			u_cid_mem_model.rf[n] = rfm[n];
		{mw, mc, mdc, mz, mto, mpd} = 13'h0003;
		iss();
		rst_b_i = 1'b0;
		repeat (4) @(negedge clk_i);
		rst_b_i = 1'b1;
		for (n = 0; n < 3000 && sleep_o !== 1'b1; n++)
			@(negedge clk_i);
		chk_st({w_o, carry_o, digit_carry_flag_o, zero_o, timeout_flag_o, powerdown_flag_o,
			sleep_o, 8'(q.size())}, {mw, mc, mdc, mz, mto, mpd, 1'b1, 8'h00});
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		if (rst_b_i !== 1'b1)
			ec = 0;
		else begin
			ec++;
			if (rf_wr_en_o === 1'b1)
				chk_wr({rf_addr_o, rf_wr_data_o, 32'(ec)});
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end

	initial begin
		{rst_b_i, ce_i, wake_i, tmr_pre_assigned_i, port_pins_i} = 12'h501;
		fail_count = 0;
		tests_run = 0;
		void'($urandom(7));
		@(negedge clk_i);
		for (t = 0; t < 6; t++) begin
			for (i = 0; i < 64; i++)
				prog[i] = (t == 0) ? ((i < 27) ? dir[i] : W_NOP) : ((i < 24) ? rnd_word() : W_SLEEP);
			for (i = 0; i < 128; i++)
				rfm[i] = 8'($urandom);
			if (t == 0)
				{rfm[34], rfm[37]} = 16'h01FF;
			else
				{tmr_pre_assigned_i, port_pins_i} = 9'($urandom);
			run_prog();
			$display("test %0d done", t);
		end
		end_of_test();
	end
endmodule

// ==== sim/cid_mem_model.sv ====
`timescale 1ns/1ps
module cid_mem_model
	import cid_pkg::*;
(
	// Clock
	input  wire logic               clk_i,
	// Program memory
	input  wire logic [10:0]        pm_addr_i,
	output logic [INSTR_W-1:0]      pm_data_o,
	// Register file
	input  wire logic [FADDR_W-1:0] rf_addr_i,
	input  wire logic               rf_rd_en_i,
	output logic [DATA_W-1:0]       rf_rd_data_o,
	input  wire logic               rf_wr_en_i,
	input  wire logic [DATA_W-1:0]  rf_wr_data_i
);
	logic [INSTR_W-1:0] rom [0:2047];
	logic [DATA_W-1:0]  rf  [0:127];

	initial rf_rd_data_o = 8'h5A;
	assign pm_data_o = rom[pm_addr_i];
	always @(posedge clk_i) begin
		if (rf_rd_en_i)
			rf_rd_data_o <= rf[rf_addr_i];
		else
			rf_rd_data_o <= ~rf_rd_data_o; // Data not held past its slot
		if (rf_wr_en_i)
			rf[rf_addr_i] <= rf_wr_data_i;
	end
endmodule

// ==== verilog/cid_alu.sv ====
`timescale 1ns/1ps
module cid_alu
	import cid_pkg::*;
(
	// Operation
	input  wire cid_alu_op_type      op_i,
	input  wire logic [BSEL_W-1:0]   bsel_i,
	input  wire logic                cin_i,
	// Operands: a is the working register
	input  wire logic [DATA_W-1:0]   a_i,
	input  wire logic [DATA_W-1:0]   b_i,
	// Result
	output logic [DATA_W-1:0]        res_o,
	output logic                     c_o,
	output logic                     dc_o,
	output logic                     z_o
);

	logic [DATA_W:0]   sum9;
	logic [NIB_W:0]    sum5;
	logic [DATA_W-1:0] mask;

	always_comb begin
		sum9  = '0;
		sum5  = '0;
		mask  = DATA_W'(1) << bsel_i;
		res_o = b_i;
		c_o   = cin_i;
		dc_o  = 1'b0;
		case (op_i)
			ALU_PASS_A: res_o = a_i;
			ALU_PASS_B: res_o = b_i;
			ALU_CLR:    res_o = DATA_ZERO;
			ALU_ADD: begin
				sum9  = {1'b0, a_i} + {1'b0, b_i};
				sum5  = {1'b0, a_i[NIB_W-1:0]} + {1'b0, b_i[NIB_W-1:0]};
				res_o = sum9[DATA_W-1:0];
				c_o   = sum9[DATA_W];
				dc_o  = sum5[NIB_W];
			end
			// b minus a, carry set means no borrow
			ALU_SUB: begin
				sum9  = {1'b0, b_i} + {1'b0, ~a_i} + (DATA_W+1)'(1);
				sum5  = {1'b0, b_i[NIB_W-1:0]} + {1'b0, ~a_i[NIB_W-1:0]} + (NIB_W+1)'(1);
				res_o = sum9[DATA_W-1:0];
				c_o   = sum9[DATA_W];
				dc_o  = sum5[NIB_W];
			end
			ALU_AND:  res_o = a_i & b_i;
			ALU_OR:   res_o = a_i | b_i;
			ALU_XOR:  res_o = a_i ^ b_i;
			ALU_COM:  res_o = ~b_i;
			ALU_DEC:  res_o = b_i - DATA_W'(1);
			ALU_INC:  res_o = b_i + DATA_W'(1);
			ALU_RLC: begin
				res_o = {b_i[DATA_W-2:0], cin_i};
				c_o   = b_i[DATA_W-1];
			end
			ALU_RRC: begin
				res_o = {cin_i, b_i[DATA_W-1:1]};
				c_o   = b_i[0];
			end
			ALU_SWAP: res_o = {b_i[NIB_W-1:0], b_i[DATA_W-1:NIB_W]};
			ALU_BCLR: res_o = b_i & ~mask;
			ALU_BSET: res_o = b_i | mask;
			default:  res_o = b_i;
		endcase
		z_o = (res_o == DATA_ZERO);
	end

endmodule

// ==== verilog/cid_core.sv ====
// Summary of operation
// - Byte ops write result to W when d is 0, to the file register when 1.
// - One instruction cycle lasts four clock periods, phases Q0 to Q3.
// - Every file register instruction reads the register before writing it.
// - Nibbles 0100, 0101, 0110 do OR, AND, XOR of W and f; only Z changes.
// - Nibble 1101 rotates f left through carry; only C changes.
// - Nibble 1100 rotates f right through carry; only C changes.
// - Nibble 1011 decrements f, skips next if zero; no flags change.
// - Nibble 1111 increments f, skips next if zero; no flags change.
// - Bit clear and set use a 3-bit bit select; no flags change.
// - Bit test skips next instruction when the selected bit is clear.
// - Bit test skips next instruction when the selected bit is set.
// - Add literal to W updates C, DC and Z.
// - Subtract W from literal into W updates C, DC and Z.
// - OR literal into W updates only Z.
// - XOR literal into W updates only Z.
// - Return with literal loads W and returns in two cycles; flags kept.
// - Standby word enters sleep and updates timeout and powerdown flags.
// - Branches and true skips take two cycles, the second a no-operation.
// - Modifying the I/O port register reads the pin levels, not the latch.
// - Writing the timer count register clears its prescaler when assigned.
`timescale 1ns/1ps
module cid_core
	import cid_pkg::*;
#(
	parameter int            PC_W        = PC_W_DEF,
	parameter int            STACK_DEPTH = STACK_DEPTH_DEF,
	parameter logic [6:0]    PORT_ADDR   = PORT_ADDR_DEF,
	parameter logic [6:0]    TIMER_ADDR  = TIMER_ADDR_DEF
) (
	// Clock, reset, enable
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                ce_i,
	// Program memory
	output logic [PC_W-1:0]          pm_addr_o,
	input  wire logic [INSTR_W-1:0]  pm_data_i,
	// Data register file
	output logic [FADDR_W-1:0]       rf_addr_o,
	output logic                     rf_rd_en_o,
	input  wire logic [DATA_W-1:0]   rf_rd_data_i,
	output logic                     rf_wr_en_o,
	output logic [DATA_W-1:0]        rf_wr_data_o,
	// Port pins and timer prescaler
	input  wire logic [DATA_W-1:0]   port_pins_i,
	input  wire logic                tmr_pre_assigned_i,
	output logic                     tmr_pre_clr_o,
	// System control
	input  wire logic                wake_i,
	output logic                     sleep_o,
	output logic                     wdt_clr_o,
	output logic                     gie_set_o,
	// Visible core state
	output logic [DATA_W-1:0]        w_o,
	output logic                     carry_o,
	output logic                     digit_carry_flag_o,
	output logic                     zero_o,
	output logic                     timeout_flag_o,
	output logic                     powerdown_flag_o
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	if (PC_W < 1 || PC_W > JUMP_W) begin : g_chk_pc
		$error("PC_W must lie between 1 and the jump field width");
	end
	if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_chk_stack
		$error("STACK_DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		cid_phase_type      ph;
		logic [PC_W-1:0]    pc;
		logic [INSTR_W-1:0] ir;
		logic [DATA_W-1:0]  w;
		logic [DATA_W-1:0]  res;
		logic               c;
		logic               dc;
		logic               z;
		logic               to;
		logic               pd;
		logic               rc;
		logic               rdc;
		logic               rz;
		logic               skip;
		logic               dummy;
		logic               dummy_adv;
		logic               hold;
		logic               sleep;
		logic [SP_W-1:0]    sp;
	} cid_core_state_type;

	cid_core_state_type s_r;
	cid_core_state_type s_nxt;

	logic [1:0]         rst_sync_r;
	logic               rst_b;

	// Result goes to file register
	function automatic logic file_dest(input logic [INSTR_W-1:0] ir);
		case (ir[PFX_HI:PFX_LO])
			PFX_BYTE: file_dest = ir[DEST_BIT];
			PFX_BIT:  file_dest = ~ir[BOP_HI];
			default:  file_dest = 1'b0;
		endcase
	endfunction

	// Instruction names a file register
	function automatic logic file_used(input logic [INSTR_W-1:0] ir);
		logic low_nib;
		low_nib   = (ir[NIB_HI:NIB_LO] == OP_MOVWF) || (ir[NIB_HI:NIB_LO] == OP_CLR);
		file_used = (ir[PFX_HI:PFX_LO] == PFX_BIT) ||
			((ir[PFX_HI:PFX_LO] == PFX_BYTE) && !(low_nib && !ir[DEST_BIT]));
	endfunction

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	// Decode
	cid_alu_op_type      alu_op;
	logic                upd_c;
	logic                upd_dc;
	logic                upd_z;
	logic                use_lit;
	logic                wr_w;
	logic                skip_zero;
	logic                test_clr;
	logic                test_set;
	logic                do_call;
	logic                do_jump;
	logic                do_ret;
	logic                do_interrupt_return;
	logic                do_sleep;
	logic                do_wdt;
	logic [FADDR_W-1:0]  faddr;
	logic [DATA_W-1:0]   opnd;
	logic [DATA_W-1:0]   alu_res;
	logic                alu_c;
	logic                alu_dc;
	logic                alu_z;
	logic                sel_bit;
	logic [PC_W-1:0]     stack_rd;

	assign faddr = s_r.ir[F_HI:0];

	always_comb begin
		alu_op    = ALU_PASS_B;
		upd_c     = 1'b0;
		upd_dc    = 1'b0;
		upd_z     = 1'b0;
		use_lit   = 1'b0;
		wr_w      = 1'b0;
		skip_zero = 1'b0;
		test_clr  = 1'b0;
		test_set  = 1'b0;
		do_call   = 1'b0;
		do_jump   = 1'b0;
		do_ret    = 1'b0;
		do_interrupt_return = 1'b0;
		do_sleep  = 1'b0;
		do_wdt    = 1'b0;
		case (s_r.ir[PFX_HI:PFX_LO])
			PFX_BYTE: begin
				wr_w  = ~s_r.ir[DEST_BIT];
				upd_z = 1'b1;
				case (s_r.ir[NIB_HI:NIB_LO])
					OP_MOVWF: begin
						alu_op = ALU_PASS_A;
						upd_z  = 1'b0;
						wr_w   = 1'b0;
						do_ret    = (s_r.ir == W_RETURN) || (s_r.ir == W_INTERRUPT_RETURN);
						do_interrupt_return = (s_r.ir == W_INTERRUPT_RETURN);
						do_wdt    = (s_r.ir == W_WATCHDOG_CLEAR_OP);
						do_sleep  = (s_r.ir == W_SLEEP);
					end
					OP_CLR:   alu_op = ALU_CLR;
					OP_SUB: begin
						alu_op = ALU_SUB;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					OP_DEC:   alu_op = ALU_DEC;
					OP_IOR:   alu_op = ALU_OR;
					OP_AND:   alu_op = ALU_AND;
					OP_XOR:   alu_op = ALU_XOR;
					OP_ADD: begin
						alu_op = ALU_ADD;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					OP_MOV:   alu_op = ALU_PASS_B;
					OP_COM:   alu_op = ALU_COM;
					OP_INC:   alu_op = ALU_INC;
					OP_DECSZ: begin
						alu_op    = ALU_DEC;
						upd_z     = 1'b0;
						skip_zero = 1'b1;
					end
					OP_RRC: begin
						alu_op = ALU_RRC;
						upd_z  = 1'b0;
						upd_c  = 1'b1;
					end
					OP_RLC: begin
						alu_op = ALU_RLC;
						upd_z  = 1'b0;
						upd_c  = 1'b1;
					end
					OP_SWAP: begin
						alu_op = ALU_SWAP;
						upd_z  = 1'b0;
					end
					OP_INCSZ: begin
						alu_op    = ALU_INC;
						upd_z     = 1'b0;
						skip_zero = 1'b1;
					end
					default:  alu_op = ALU_PASS_B;
				endcase
			end
			PFX_BIT: begin
				case (s_r.ir[BOP_HI:BOP_LO])
					BOP_CLR: alu_op = ALU_BCLR;
					BOP_SET: alu_op = ALU_BSET;
					BOP_TSC: test_clr = 1'b1;
					BOP_TSS: test_set = 1'b1;
					default: alu_op = ALU_PASS_B;
				endcase
			end
			PFX_CTRL: begin
				do_call = ~s_r.ir[JUMP_BIT];
				do_jump = s_r.ir[JUMP_BIT];
			end
			default: begin
				use_lit = 1'b1;
				wr_w    = 1'b1;
				upd_z   = 1'b1;
				casez (s_r.ir[NIB_HI:NIB_LO])
					LOP_MOV: upd_z = 1'b0;
					LOP_RET: begin
						upd_z  = 1'b0;
						do_ret = 1'b1;
					end
					LOP_IOR: alu_op = ALU_OR;
					LOP_AND: alu_op = ALU_AND;
					LOP_XOR: alu_op = ALU_XOR;
					LOP_SUB: begin
						alu_op = ALU_SUB;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					LOP_ADD: begin
						alu_op = ALU_ADD;
						upd_c  = 1'b1;
						upd_dc = 1'b1;
					end
					default: alu_op = ALU_PASS_B;
				endcase
			end
		endcase
	end

	// Port register reads the pins
	always_comb begin
		if (use_lit) begin
			opnd = s_r.ir[LIT_HI:0];
		end else if (faddr == PORT_ADDR) begin
			opnd = port_pins_i;
		end else begin
			opnd = rf_rd_data_i;
		end
	end

	assign sel_bit = opnd[s_r.ir[BSEL_HI:BSEL_LO]];

	cid_alu u_alu (
		.op_i   (alu_op),
		.bsel_i (s_r.ir[BSEL_HI:BSEL_LO]),
		.cin_i  (s_r.c),
		.a_i    (s_r.w),
		.b_i    (opnd),
		.res_o  (alu_res),
		.c_o    (alu_c),
		.dc_o   (alu_dc),
		.z_o    (alu_z)
	);

	logic push;

	assign push = ce_i && (s_r.ph == PH_Q3) && do_call;

	cid_stack #(
		.WIDTH (PC_W),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b),
		.ce_i      (ce_i),
		.wr_en_i   (push),
		.wr_addr_i (s_r.sp),
		.wr_data_i (s_r.pc + PC_W'(1)),
		.rd_addr_i (s_r.sp - SP_W'(1)),
		.rd_data_o (stack_rd)
	);

	// Phase sequencer and execution
	always_comb begin
		s_nxt = s_r;
		case (s_r.ph)
			PH_Q0: begin
				if (s_r.sleep) begin
					s_nxt.sleep = ~wake_i;
				end else begin
					// Discarded slot runs as a no-operation
					s_nxt.ir    = s_r.dummy ? W_NOP : pm_data_i;
					s_nxt.hold  = s_r.dummy & ~s_r.dummy_adv;
					s_nxt.dummy = 1'b0;
					s_nxt.ph    = PH_Q1;
				end
			end
			PH_Q1: s_nxt.ph = PH_Q2;
			PH_Q2: begin
				s_nxt.res  = alu_res;
				s_nxt.rc   = alu_c;
				s_nxt.rdc  = alu_dc;
				s_nxt.rz   = alu_z;
				s_nxt.skip = (skip_zero & alu_z) | (test_clr & ~sel_bit) |
					(test_set & sel_bit);
				s_nxt.ph   = PH_Q3;
			end
			PH_Q3: begin
				s_nxt.ph = PH_Q0;
				if (wr_w) begin
					s_nxt.w = s_r.res;
				end
				if (upd_c) begin
					s_nxt.c = s_r.rc;
				end
				if (upd_dc) begin
					s_nxt.dc = s_r.rdc;
				end
				if (upd_z) begin
					s_nxt.z = s_r.rz;
				end
				s_nxt.pc = s_r.hold ? s_r.pc : s_r.pc + PC_W'(1);
				if (do_call || do_jump) begin
					s_nxt.pc        = s_r.ir[PC_W-1:0];
					s_nxt.dummy     = 1'b1;
					s_nxt.dummy_adv = 1'b0;
				end
				if (do_call) begin
					s_nxt.sp = s_r.sp + SP_W'(1);
				end
				if (do_ret) begin
					s_nxt.pc        = stack_rd;
					s_nxt.sp        = s_r.sp - SP_W'(1);
					s_nxt.dummy     = 1'b1;
					s_nxt.dummy_adv = 1'b0;
				end
				if (s_r.skip) begin
					s_nxt.dummy     = 1'b1;
					s_nxt.dummy_adv = 1'b1;
				end
				if (do_wdt) begin
					s_nxt.to = 1'b1;
					s_nxt.pd = 1'b1;
				end
				if (do_sleep) begin
					s_nxt.to    = 1'b1;
					s_nxt.pd    = 1'b0;
					s_nxt.sleep = 1'b1;
				end
			end
			default: s_nxt.ph = PH_Q0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			s_r    <= '0;
			s_r.ph <= PH_Q0;
			s_r.to <= TO_RST;
			s_r.pd <= PD_RST;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// Read always precedes the write of a file instruction
	assign rf_rd_en_o    = ce_i && (s_r.ph == PH_Q1) && file_used(s_r.ir);
	assign rf_wr_en_o    = ce_i && (s_r.ph == PH_Q3) && file_dest(s_r.ir);
	assign tmr_pre_clr_o = rf_wr_en_o && (faddr == TIMER_ADDR) && tmr_pre_assigned_i;
	assign wdt_clr_o     = ce_i && (s_r.ph == PH_Q3) && do_wdt;
	assign gie_set_o     = ce_i && (s_r.ph == PH_Q3) && do_interrupt_return;

	assign rf_addr_o          = faddr;
	assign rf_wr_data_o       = s_r.res;
	assign pm_addr_o          = s_r.pc;
	assign sleep_o            = s_r.sleep;
	assign w_o                = s_r.w;
	assign carry_o            = s_r.c;
	assign digit_carry_flag_o = s_r.dc;
	assign zero_o             = s_r.z;
	assign timeout_flag_o     = s_r.to;
	assign powerdown_flag_o   = s_r.pd;

endmodule

// ==== verilog/cid_stack.sv ====
`timescale 1ns/1ps
module cid_stack
	import cid_pkg::*;
#(
	parameter int WIDTH = PC_W_DEF,
	parameter int DEPTH = STACK_DEPTH_DEF,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             ce_i,
	// Write port
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	// Registered read port
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic [WIDTH-1:0]      rd_data_o
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} cid_stack_state_type;

	cid_stack_state_type s_r;
	cid_stack_state_type s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.rd = s_r.mem[rd_addr_i];
		if (wr_en_i) begin
			s_nxt.mem[wr_addr_i] = wr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign rd_data_o = s_r.rd;

endmodule
